// ==== include/pmt_pkg.sv ====
// Package with constants for the program memory and table read block.
package pmt_pkg;
   localparam int ADDR_W       = 11;
   localparam int WORD_W       = 16;
   localparam int DEPTH        = 2048;
   localparam int BYTE_W       = 8;
   localparam logic [10:0] RESET_VECTOR = 11'h000;
   localparam logic [2:0]  LAST_PAGE    = 3'h7;
   localparam logic [7:0]  PC_LOW_RESET = 8'h00;
   localparam logic [15:0] MEM_FILL     = 16'h0000;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   // Register offsets on the plain register port.
   localparam logic [3:0] REG_PC_LOW    = 4'h0;
   localparam logic [3:0] REG_TBL_LOW   = 4'h1;
   localparam logic [3:0] REG_TBL_HIGH  = 4'h2;
   localparam logic [3:0] REG_HIGH_LAT  = 4'h3;
   localparam logic [3:0] REG_PC_HIGH   = 4'h4;
   localparam int REG_AW = 4;
   typedef enum logic [1:0] {
      PMT_OP_NONE,
      PMT_OP_PAGED,
      PMT_OP_LAST,
      PMT_OP_FULL
   } pmt_op_t;
endpackage

// ==== logic/pmt_store.sv ====
// Program word store: flip-flop array with one write and two read ports.
`timescale 1ns/100ps
`default_nettype none
module pmt_store #(
   parameter int AW = 11,
   parameter int DW = 16,
   parameter int DEPTH = 2048
) (
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   input  wire logic          load_en_i,
   input  wire logic [AW-1:0] load_addr_i,
   input  wire logic [DW-1:0] load_data_i,
   input  wire logic [AW-1:0] fetch_addr_i,
   output logic      [DW-1:0] fetch_data_o,
   input  wire logic [AW-1:0] table_addr_i,
   output logic      [DW-1:0] table_data_o
);
   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] next_mem [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_word
         always_comb begin
            next_mem[g] = mem[g];
            if (load_en_i && load_addr_i == AW'(g)) begin
               next_mem[g] = load_data_i;
            end
         end
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               mem[g] <= pmt_pkg::MEM_FILL;
            end else begin
               mem[g] <= next_mem[g];
            end
         end
      end
   endgenerate

   assign fetch_data_o = mem[fetch_addr_i];
   assign table_data_o = mem[table_addr_i];
endmodule // pmt_store
`default_nettype wire

// ==== logic/pmt_top.sv ====
// Program counter, program store access and table read path.
//
// Contract
// RULE1: Store holds 2K words of 16 bits, for fetch and table data.
// RULE2: Any reset loads the program counter with address zero.
// RULE3: Table address is formed from both pointer registers together.
// RULE4: Table read writes the low byte to the named data register.
// RULE5: Table read captures the high byte into the high byte latch.
// RULE6: High byte latch is readable, software writes to it are ignored.
// RULE7: Table instructions take two cycles, stalling fetch one extra cycle.
// RULE8: Paged read uses low pointer as offset in page of high pointer.
// RULE9: Program counter is 11 bits; only its low byte is software visible.
// RULE10: Last page read uses the last page and ignores the high pointer.
`timescale 1ns/100ps
`default_nettype none
module pmt_top #(
   parameter int AW    = pmt_pkg::ADDR_W,
   parameter int DW    = pmt_pkg::WORD_W,
   parameter int DEPTH = pmt_pkg::DEPTH
) (
   input  wire logic                      clk_i,
   input  wire logic                      sys_rst_i,
   // Register port.
   input  wire logic [pmt_pkg::REG_AW-1:0] reg_addr_i,
   input  wire logic [7:0]                reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [7:0]                reg_rdata_o,
   // Core side.
   input  wire logic                      advance_i,
   input  wire logic                      jump_i,
   input  wire logic [AW-1:0]             jump_addr_i,
   input  wire pmt_pkg::pmt_op_t          table_op_i,
   input  wire logic [7:0]                table_dest_i,
   output logic      [AW-1:0]             pc_o,
   output logic      [DW-1:0]             instr_o,
   output logic                           stall_o,
   output logic                           dm_wr_o,
   output logic      [7:0]                dm_addr_o,
   output logic      [7:0]                dm_wdata_o,
   // Store loading.
   input  wire logic                      load_en_i,
   input  wire logic [AW-1:0]             load_addr_i,
   input  wire logic [DW-1:0]             load_data_i
);
   localparam int PW = AW - pmt_pkg::BYTE_W;

   logic [AW-1:0] pc, next_pc;
   logic [7:0]    tbl_low, next_tbl_low;
   logic [PW-1:0] tbl_high, next_tbl_high;
   logic [7:0]    table_high_byte_latch, next_table_high_byte_latch;
   logic          busy, next_busy;
   logic [AW-1:0] taddr, next_taddr;
   logic [7:0]    dest, next_dest;
   logic          dm_wr, next_dm_wr;
   logic [7:0]    dm_wdata, next_dm_wdata;
   logic [7:0]    rdata, next_rdata;
   logic [DW-1:0] fetch_word;
   logic [DW-1:0] table_word;
   logic [AW-1:0] addr_sel;

   pmt_store #(.AW(AW), .DW(DW), .DEPTH(DEPTH)) u_store ( // see RULE1
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .load_en_i    (load_en_i),
      .load_addr_i  (load_addr_i),
      .load_data_i  (load_data_i),
      .fetch_addr_i (pc),
      .fetch_data_o (fetch_word),
      .table_addr_i (taddr),
      .table_data_o (table_word)
   );

   // Address of the pending table access chosen by instruction variant.
   always_comb begin
      case (table_op_i)
         pmt_pkg::PMT_OP_LAST:
            addr_sel = {pmt_pkg::LAST_PAGE, tbl_low}; // see RULE10
         pmt_pkg::PMT_OP_PAGED:
            addr_sel = {tbl_high, tbl_low}; // see RULE8
         pmt_pkg::PMT_OP_FULL:
            addr_sel = {tbl_high, tbl_low}; // see RULE3
         default:
            addr_sel = {tbl_high, tbl_low};
      endcase
   end

   always_comb begin
      next_pc = pc;
      next_tbl_low = tbl_low;
      next_tbl_high = tbl_high;
      next_table_high_byte_latch = table_high_byte_latch;
      next_busy = 1'b0;
      next_taddr = taddr;
      next_dest = dest;
      next_dm_wr = 1'b0;
      next_dm_wdata = dm_wdata;
      next_rdata = rdata;
      if (busy) begin
         // Second cycle: the word is read, fetch is held this cycle.
         next_dm_wr = 1'b1;
         next_dm_wdata = table_word[pmt_pkg::BYTE_W-1:0]; // see RULE4
         next_table_high_byte_latch =
            table_word[DW-1:pmt_pkg::BYTE_W]; // see RULE5
      end else if (table_op_i != pmt_pkg::PMT_OP_NONE) begin
         next_busy = 1'b1; // see RULE7
         next_taddr = addr_sel;
         next_dest = table_dest_i;
         next_pc = AW'(pc + 1'b1);
      end else if (jump_i) begin
         next_pc = jump_addr_i;
      end else if (advance_i) begin
         next_pc = AW'(pc + 1'b1);
      end
      if (reg_wr_i) begin
         case (reg_addr_i)
            pmt_pkg::REG_PC_LOW:
               next_pc = {pc[AW-1:pmt_pkg::BYTE_W], reg_wdata_i}; // see RULE9
            pmt_pkg::REG_TBL_LOW:  next_tbl_low = reg_wdata_i;
            pmt_pkg::REG_TBL_HIGH: next_tbl_high = reg_wdata_i[PW-1:0];
            // Latch and high PC bits ignore writes; see RULE6
            default: next_tbl_low = tbl_low;
         endcase
      end
      next_rdata = pmt_pkg::BYTE_RESET;
      if (reg_rd_i) begin
         case (reg_addr_i)
            pmt_pkg::REG_PC_LOW:
               next_rdata = pc[pmt_pkg::BYTE_W-1:0]; // see RULE9
            pmt_pkg::REG_TBL_LOW:  next_rdata = tbl_low;
            pmt_pkg::REG_TBL_HIGH: next_rdata = 8'(tbl_high);
            pmt_pkg::REG_HIGH_LAT:
               next_rdata = table_high_byte_latch; // see RULE6
            default: next_rdata = pmt_pkg::BYTE_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pc <= pmt_pkg::RESET_VECTOR; // see RULE2
         tbl_low <= pmt_pkg::BYTE_RESET;
         tbl_high <= '0;
         table_high_byte_latch <= pmt_pkg::BYTE_RESET;
         busy <= 1'b0;
         taddr <= '0;
         dest <= pmt_pkg::BYTE_RESET;
         dm_wr <= 1'b0;
         dm_wdata <= pmt_pkg::BYTE_RESET;
         rdata <= pmt_pkg::BYTE_RESET;
      end else begin
         pc <= next_pc;
         tbl_low <= next_tbl_low;
         tbl_high <= next_tbl_high;
         table_high_byte_latch <= next_table_high_byte_latch;
         busy <= next_busy;
         taddr <= next_taddr;
         dest <= next_dest;
         dm_wr <= next_dm_wr;
         dm_wdata <= next_dm_wdata;
         rdata <= next_rdata;
      end
   end

   assign pc_o = pc;
   assign instr_o = fetch_word;
   assign stall_o = busy;
   assign dm_wr_o = dm_wr;
   assign dm_addr_o = dest;
   assign dm_wdata_o = dm_wdata;
   assign reg_rdata_o = rdata;

   // Checks.
   property p_reset_vec;
      @(posedge clk_i) $fell(sys_rst_i) |-> pc == pmt_pkg::RESET_VECTOR;
   endproperty
   a_reset_vec: assert property (p_reset_vec) // see RULE2
      else $error("pc not zero");

   property p_two_cycle;
      @(posedge clk_i) disable iff (sys_rst_i)
      (!busy && table_op_i != pmt_pkg::PMT_OP_NONE)
      |=> busy ##1 (!busy && dm_wr);
   endproperty
   a_two_cycle: assert property (p_two_cycle) // see RULE7
      else $error("bad table timing");

   property p_low_byte;
      @(posedge clk_i) disable iff (sys_rst_i)
      busy |=> dm_wr && dm_addr_o == $past(dest)
         && dm_wdata == $past(table_word[pmt_pkg::BYTE_W-1:0]);
   endproperty
   a_low_byte: assert property (p_low_byte) // see RULE4
      else $error("bad low byte");

   property p_high_byte;
      @(posedge clk_i) disable iff (sys_rst_i)
      busy |=> table_high_byte_latch
         == $past(table_word[DW-1:pmt_pkg::BYTE_W]);
   endproperty
   a_high_byte: assert property (p_high_byte) // see RULE5
      else $error("bad latch");

   property p_latch_ro;
      @(posedge clk_i) disable iff (sys_rst_i)
      !busy |=> $stable(table_high_byte_latch);
   endproperty
   a_latch_ro: assert property (p_latch_ro) // see RULE6
      else $error("latch changed");

   property p_last_page;
      @(posedge clk_i) disable iff (sys_rst_i)
      (!busy && table_op_i == pmt_pkg::PMT_OP_LAST)
      |=> taddr == {pmt_pkg::LAST_PAGE, $past(tbl_low)};
   endproperty
   a_last_page: assert property (p_last_page) // see RULE10
      else $error("bad last page");

   property p_paged;
      @(posedge clk_i) disable iff (sys_rst_i)
      (!busy && table_op_i == pmt_pkg::PMT_OP_PAGED)
      |=> taddr == {$past(tbl_high), $past(tbl_low)};
   endproperty
   a_paged: assert property (p_paged) // see RULE8
      else $error("bad paged addr");

   property p_full;
      @(posedge clk_i) disable iff (sys_rst_i)
      (!busy && table_op_i == pmt_pkg::PMT_OP_FULL)
      |=> taddr == {$past(tbl_high), $past(tbl_low)};
   endproperty
   a_full: assert property (p_full) // see RULE3
      else $error("bad table addr");

   property p_pc_low;
      @(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == pmt_pkg::REG_PC_LOW)
      |=> pc[pmt_pkg::BYTE_W-1:0] == $past(reg_wdata_i);
   endproperty
   a_pc_low: assert property (p_pc_low) // see RULE9
      else $error("pc low write lost");

   c_paged: cover property (@(posedge clk_i)
      table_op_i == pmt_pkg::PMT_OP_PAGED ##2 dm_wr);
   c_last: cover property (@(posedge clk_i)
      table_op_i == pmt_pkg::PMT_OP_LAST ##2 dm_wr);
   c_jump: cover property (@(posedge clk_i) jump_i && !busy);
endmodule // pmt_top
`default_nettype wire

// ==== tb/pmt_dmem_model.sv ====
// Data memory model that takes the table read writes from the block.
`timescale 1ns/100ps
`default_nettype none
module pmt_dmem_model (
   input  wire logic       clk_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [7:0] rd_addr_i,
   output logic      [7:0] rd_data_o
);
   logic [7:0] mem [0:255];
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
   // Unwritten places read as unknown, so a lost write never passes.
   assign rd_data_o = mem[rd_addr_i];
endmodule // pmt_dmem_model
`default_nettype wire

// ==== tb/program_memory_table_read_tb.sv ====
// Self-checking bench for the program memory and table read block.
`timescale 1ns/100ps
`default_nettype none
module program_memory_table_read_tb;
   logic             clk_i = 1'b0;
   logic             sys_rst_i = 1'b1;
   logic [3:0]       reg_addr_i = 4'h0;
   logic [7:0]       reg_wdata_i = 8'h00;
   logic [7:0]       table_dest_i = 8'h00;
   logic             reg_wr_i = 1'b0;
   logic             reg_rd_i = 1'b0;
   logic             advance_i = 1'b0;
   logic             jump_i = 1'b0;
   logic             load_en_i = 1'b0;
   logic [10:0]      jump_addr_i = 11'h000;
   logic [10:0]      load_addr_i = 11'h000;
   logic [15:0]      load_data_i = 16'h0000;
   pmt_pkg::pmt_op_t table_op_i = pmt_pkg::PMT_OP_NONE;
   pmt_pkg::pmt_op_t op;
   logic [7:0]       reg_rdata_o, dm_addr_o, dm_wdata_o, dm_rd, dm_q, lo, hi;
   logic [10:0]      pc_o, a;
   logic [15:0]      instr_o;
   logic [15:0]      mem_exp [0:2047];
   logic             stall_o, dm_wr_o;
   int               failures = 0, num_checks = 0, seed = 21, cycles = 0;

   pmt_top dut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .advance_i, .jump_i, .jump_addr_i,
      .table_op_i, .table_dest_i, .pc_o, .instr_o, .stall_o, .dm_wr_o,
      .dm_addr_o, .dm_wdata_o, .load_en_i, .load_addr_i, .load_data_i);
   pmt_dmem_model u_dmem (.clk_i, .wr_i(dm_wr_o), .addr_i(dm_addr_o),
      .wdata_i(dm_wdata_o), .rd_addr_i(dm_rd), .rd_data_o(dm_q));

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // The ceiling is over twenty times what the sequence below needs.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         complete_run;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] ad, output logic [7:0] q);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= ad;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 q = reg_rdata_o;
   endtask

   task automatic ld(input logic [10:0] ad, input logic [15:0] d);
      @(posedge clk_i);
      load_en_i <= 1'b1;
      load_addr_i <= ad;
      load_data_i <= d;
      mem_exp[ad] = d;
      @(posedge clk_i);
      load_en_i <= 1'b0;
   endtask

   task automatic tread(input pmt_pkg::pmt_op_t o, input logic [7:0] d,
                        input logic [15:0] e);
      logic [10:0] p;
      // Read the counter once it has settled, not in the edge's time step.
      #1 p = pc_o;
      @(posedge clk_i);
      table_op_i <= o;
      table_dest_i <= d;
      advance_i <= 1'b1;
      @(posedge clk_i);
      table_op_i <= pmt_pkg::PMT_OP_NONE;
      #1 chk(stall_o, 1'b1);
      chk(pc_o, p + 11'h001);
      @(posedge clk_i);
      advance_i <= 1'b0;
      #1 chk(pc_o, p + 11'h001);
      chk(dm_wr_o, 1'b1);
      chk(dm_addr_o, d);
      chk(dm_wdata_o, e[7:0]);
   endtask

   function automatic logic [10:0] taddr(pmt_pkg::pmt_op_t o,
                                         logic [7:0] l, logic [7:0] h);
      return (o == pmt_pkg::PMT_OP_LAST) ? {pmt_pkg::LAST_PAGE, l}
                                         : {h[2:0], l};
   endfunction

   initial begin
      logic [7:0] q;
      for (int i = 0; i < 2048; i++) mem_exp[i] = 16'h0000;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1 chk(pc_o, pmt_pkg::RESET_VECTOR);
      ld(11'h000, 16'($random(seed)));
      ld(11'h7ff, 16'($random(seed)));
      #1 chk(instr_o, mem_exp[0]);
      // Jump and advance together: the jump must win, then advance alone.
      @(posedge clk_i);
      jump_i <= 1'b1;
      jump_addr_i <= 11'h7fe;
      advance_i <= 1'b1;
      @(posedge clk_i);
      jump_i <= 1'b0;
      #1 chk(pc_o, 11'h7fe);
      @(posedge clk_i);
      advance_i <= 1'b0;
      #1 chk(instr_o, mem_exp[11'h7ff]);
      wr(pmt_pkg::REG_PC_LOW, 8'h05);
      #1 chk(pc_o, 11'h705);
      rd(pmt_pkg::REG_PC_LOW, q);
      chk(q, 8'h05);
      rd(pmt_pkg::REG_PC_HIGH, q);
      chk(q, 8'h00);
      for (int i = 0; i < 40; i++) begin
         lo = 8'($random(seed));
         hi = 8'($random(seed));
         if (i < 2) lo = {8{i[0]}};
         op = pmt_pkg::pmt_op_t'(2'(1 + i % 3));
         a = taddr(op, lo, hi);
         // A decoy at the pointer pair shows a last page read that used it.
         ld({hi[2:0], lo}, 16'($random(seed)));
         ld(a, 16'($random(seed)));
         wr(pmt_pkg::REG_TBL_LOW, lo);
         wr(pmt_pkg::REG_TBL_HIGH, hi);
         rd(pmt_pkg::REG_TBL_LOW, q);
         chk(q, lo);
         rd(pmt_pkg::REG_TBL_HIGH, q);
         chk(q, {5'h00, hi[2:0]});
         tread(op, 8'(8'h80 + i), mem_exp[a]);
         rd(pmt_pkg::REG_HIGH_LAT, q);
         chk(q, mem_exp[a][15:8]);
         wr(pmt_pkg::REG_HIGH_LAT, ~q);
         rd(pmt_pkg::REG_HIGH_LAT, q);
         chk(q, mem_exp[a][15:8]);
         dm_rd = 8'(8'h80 + i);
         #1 chk(dm_q, mem_exp[a][7:0]);
      end
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1 chk(pc_o, pmt_pkg::RESET_VECTOR);
      complete_run;
   end
endmodule // program_memory_table_read_tb
`default_nettype wire
